// *** core/fbm_monitor.sv ***
`timescale 1ns/100ps
// ------------------------------------------------------------
// fieldbus configuration and telegram-loss supervision
// ------------------------------------------------------------
module fbm_monitor #(
    parameter int unsigned TICK_CYC = fbm_pkg::TICK_CYC,
    parameter logic [1:0] PROTO_MAX = fbm_pkg::PROTO_MAX_DEF
) (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire fbm_pkg::fbm_cfg_type cfg_i,
    input wire logic [7:0] addr_sw_i,
    input wire logic [1:0] fw_proto_i,
    input wire logic fw_load_ok_i,
    input wire logic telegram_ok_i,
    output fbm_pkg::fbm_cfg_type cfg_active_o,
    output logic proto_valid_o,
    output logic fw_load_start_o,
    output logic fw_loading_o,
    output logic fw_load_fail_o,
    output logic restart_req_o,
    output logic can_on_o,
    output logic [2:0] can_profile_o,
    output logic stack_service_o,
    output logic io_service_o,
    output logic [6:0] node_addr_o,
    output logic [9:0] can_kbps_o,
    output logic rate_valid_o,
    output logic wd_armed_o,
    output logic bus_timeout_o,
    output logic shutdown_o
);
    import fbm_pkg::*;

    // protocol codes beyond what the firmware offers are refused
    if (PROTO_MAX > PROTO_MAX_DEF) begin : g_chk
        $error("fbm_monitor: PROTO_MAX above 3");
    end

    localparam logic [SEC_W-1:0] BOOT_SEC = SEC_W'(BOOT_WIN_S); // boot window
    localparam logic [SEC_W-1:0] LOAD_SEC = SEC_W'(LOAD_MAX_S); // load limit

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // bit-rate code to kbit/s, zero for unassigned codes
    function automatic logic [9:0] rate_kbps(input logic [3:0] code);
        logic [9:0] r;
        r = KBPS_NONE;
        case (code)
            4'h0: r = KBPS_1000;
            4'h2: r = KBPS_500;
            4'h3: r = KBPS_250;
            4'h4: r = KBPS_125;
            4'h6: r = KBPS_50;
            4'h7: r = KBPS_20;
            4'h8: r = KBPS_10;
            default: r = KBPS_NONE;
        endcase
        return r;
    endfunction : rate_kbps

    // saturating seconds increment
    function automatic logic [SEC_W-1:0] sec_inc(input logic [SEC_W-1:0] v);
        return (&v) ? v : v + 1'b1;
    endfunction : sec_inc

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        fbm_phase_type phase; // start-up sequence
        fbm_cfg_type act; // configuration frozen at start
        logic proto_ok; // frozen protocol code legal
        logic [6:0] addr; // node address in use
        logic [SEC_W-1:0] boot_s; // seconds since power-up
        logic boot_win; // service window open
        logic [SEC_W-1:0] load_s; // seconds spent loading
        logic load_start; // load request pulse
        logic load_fail; // load ran over time
        logic restart; // restart request pulse
        logic armed; // watchdog armed
        logic [SEC_W-1:0] quiet_s; // seconds without telegram
        logic tripped; // bus timeout latched
    } fbm_st_type;

    fbm_st_type st_ff; // state
    fbm_st_type nxt_st; // next state
    logic sec_tick; // one-second enable
    logic tick_clr; // restart the second divider
    logic [2:0] mode_in; // can mode, clamped
    logic mon_on; // monitoring enabled

    // ------------------------------------------------------------
    // second divider
    // ------------------------------------------------------------
    // a telegram also restarts the divider so silence is measured whole
    assign tick_clr = telegram_ok_i;

    fbm_tick #(
        .TICK_CYC(TICK_CYC)
    ) u_tick (
        .core_clk_i(core_clk_i),
        .rst_n_i(rst_n_i),
        .clear_i(tick_clr),
        .tick_o(sec_tick)
    );

    // out-of-range mode falls back to off rather than a phantom profile
    assign mode_in = (cfg_i.can_mode > CAN_MODE_MAX) ? CAN_OFF : cfg_i.can_mode;
    assign mon_on = (st_ff.act.timeout_s != TMO_OFF);

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        nxt_st = st_ff;
        nxt_st.load_start = 1'b0;
        nxt_st.restart = 1'b0;

        // boot window counts only the first seconds after power-up
        if (st_ff.boot_win && sec_tick) begin
            nxt_st.boot_s = sec_inc(st_ff.boot_s);
            if (sec_inc(st_ff.boot_s) >= BOOT_SEC) begin
                nxt_st.boot_win = 1'b0;
            end
        end

        case (st_ff.phase)
            PH_CAPTURE: begin
                // parameters are read once; later writes wait for restart
                nxt_st.act = cfg_i;
                nxt_st.act.can_mode = mode_in;
                nxt_st.act.timeout_s = (cfg_i.timeout_s > TMO_MAX) ? TMO_MAX : cfg_i.timeout_s;
                nxt_st.proto_ok = (cfg_i.proto <= PROTO_MAX);
                // switches at 00 hand the address to the parameter
                nxt_st.addr = (addr_sw_i == SW_USE_PARAM) ? cfg_i.node_addr : addr_sw_i[6:0];
                if ((cfg_i.proto <= PROTO_MAX) && (cfg_i.proto != fw_proto_i)) begin
                    // protocol differs from loaded firmware: load now
                    nxt_st.phase = PH_LOADING;
                    nxt_st.load_start = 1'b1;
                    nxt_st.load_s = '0;
                end else begin
                    nxt_st.phase = PH_RUN;
                end
            end
            PH_LOADING: begin
                // power must stay on here; nothing can protect a cut supply
                if (fw_load_ok_i) begin
                    nxt_st.restart = 1'b1;
                    nxt_st.phase = PH_RUN;
                end else if (sec_tick) begin
                    nxt_st.load_s = sec_inc(st_ff.load_s);
                    if (sec_inc(st_ff.load_s) >= LOAD_SEC) begin
                        nxt_st.load_fail = 1'b1;
                        nxt_st.phase = PH_FAILED;
                    end
                end
            end
            PH_RUN: begin
                // first good telegram arms the watchdog
                if (telegram_ok_i) begin
                    nxt_st.armed = 1'b1;
                    nxt_st.quiet_s = '0;
                end else if (st_ff.armed && mon_on && sec_tick && !st_ff.tripped) begin
                    nxt_st.quiet_s = sec_inc(st_ff.quiet_s);
                    if (sec_inc(st_ff.quiet_s) >= st_ff.act.timeout_s) begin
                        // latched until restart, the drive stays down
                        nxt_st.tripped = 1'b1;
                    end
                end
            end
            PH_FAILED: begin
                // hold; only a power cycle leaves this phase
                nxt_st.phase = PH_FAILED;
            end
            default: begin
                nxt_st.phase = PH_CAPTURE;
            end
        endcase
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_ff.phase <= PH_CAPTURE;
            st_ff.act.proto <= PROTO_DEF;
            st_ff.act.can_mode <= CAN_DEF;
            st_ff.act.node_addr <= ADDR_DEF;
            st_ff.act.rate_code <= RATE_DEF;
            st_ff.act.timeout_s <= TMO_DEF;
            st_ff.proto_ok <= 1'b0;
            st_ff.addr <= ADDR_DEF;
            st_ff.boot_s <= '0;
            st_ff.boot_win <= 1'b1;
            st_ff.load_s <= '0;
            st_ff.load_start <= 1'b0;
            st_ff.load_fail <= 1'b0;
            st_ff.restart <= 1'b0;
            st_ff.armed <= 1'b0;
            st_ff.quiet_s <= '0;
            st_ff.tripped <= 1'b0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign cfg_active_o = st_ff.act;
    assign proto_valid_o = st_ff.proto_ok;
    assign fw_load_start_o = st_ff.load_start;
    assign fw_loading_o = (st_ff.phase == PH_LOADING);
    assign fw_load_fail_o = st_ff.load_fail;
    assign restart_req_o = st_ff.restart;
    assign can_on_o = (st_ff.act.can_mode != CAN_OFF);
    // profile instance 1..5, zero when not in a profile mode
    assign can_profile_o = (st_ff.act.can_mode > CAN_GENERIC) ? st_ff.act.can_mode - CAN_GENERIC : CAN_OFF;
    // can takes the stack port, except in the boot window
    assign stack_service_o = (st_ff.act.can_mode == CAN_OFF) || st_ff.boot_win;
    assign io_service_o = (st_ff.act.can_mode != CAN_OFF);
    assign node_addr_o = st_ff.addr;
    assign can_kbps_o = rate_kbps(st_ff.act.rate_code);
    assign rate_valid_o = (rate_kbps(st_ff.act.rate_code) != KBPS_NONE);
    assign wd_armed_o = st_ff.armed && mon_on;
    assign bus_timeout_o = st_ff.tripped;
    assign shutdown_o = st_ff.tripped;

endmodule : fbm_monitor

// *** core/fbm_pkg.sv ***
// How it works
// - protocol codes 0..3 select four ethernet protocols
// - new protocol loads at power-up, then restarts
// - can mode: 0 off, 1 on, 2..6 profiles
// - can on moves service link to io module
// - first 5 s keep stack service port reachable
// - node address used only when switches 00
// - new node address applies after restart only
// - bit-rate code maps to seven fixed rates
// - telegram silence past timeout trips bus error
// - watchdog unarmed until first good telegram
// - timeout zero disables telegram loss monitoring
package fbm_pkg;

    // ------------------------------------------------------------
    // clock and time
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ = 125_000_000; // core clock rate
    localparam int unsigned TICK_S = 1; // base tick, seconds
    localparam int unsigned TICK_CYC = CLK_HZ * TICK_S; // cycles per tick
    localparam int unsigned BOOT_WIN_S = 5; // service window after power-up
    localparam int unsigned LOAD_MAX_S = 120; // two minutes protocol load
    localparam int unsigned TICK_W = 27; // width of tick counter

    // ------------------------------------------------------------
    // field widths and limits
    // ------------------------------------------------------------
    localparam int unsigned SEC_W = 7; // seconds counters
    localparam logic [1:0] PROTO_MAX_DEF = 2'h3; // highest protocol code
    localparam logic [2:0] CAN_MODE_MAX = 3'h6; // highest can mode code
    localparam logic [2:0] CAN_OFF = 3'h0; // can inactive
    localparam logic [2:0] CAN_GENERIC = 3'h1; // generic can
    localparam logic [6:0] TMO_MAX = 7'h64; // 100 s upper limit
    localparam logic [6:0] TMO_OFF = 7'h00; // monitoring disabled
    localparam logic [7:0] SW_USE_PARAM = 8'h00; // switches select parameter
    localparam logic [1:0] PROTO_DEF = 2'h0; // reset value protocol
    localparam logic [2:0] CAN_DEF = 3'h0; // reset value can mode
    localparam logic [6:0] ADDR_DEF = 7'h00; // reset value node address
    localparam logic [3:0] RATE_DEF = 4'h2; // reset value rate code
    localparam logic [6:0] TMO_DEF = 7'h05; // reset value timeout

    // ------------------------------------------------------------
    // bit-rate table, kbit/s
    // ------------------------------------------------------------
    localparam logic [9:0] KBPS_1000 = 10'h3e8;
    localparam logic [9:0] KBPS_500 = 10'h1f4;
    localparam logic [9:0] KBPS_250 = 10'h0fa;
    localparam logic [9:0] KBPS_125 = 10'h07d;
    localparam logic [9:0] KBPS_50 = 10'h032;
    localparam logic [9:0] KBPS_20 = 10'h014;
    localparam logic [9:0] KBPS_10 = 10'h00a;
    localparam logic [9:0] KBPS_NONE = 10'h000;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef struct packed {
        logic [1:0] proto; // ethernet protocol code
        logic [2:0] can_mode; // can mode code
        logic [6:0] node_addr; // node address parameter
        logic [3:0] rate_code; // can bit-rate code
        logic [6:0] timeout_s; // telegram timeout, seconds
    } fbm_cfg_type;

    typedef enum logic [1:0] {
        PH_CAPTURE,
        PH_LOADING,
        PH_RUN,
        PH_FAILED
    } fbm_phase_type;

endpackage : fbm_pkg

// *** core/fbm_tick.sv ***
`timescale 1ns/100ps
// ------------------------------------------------------------
// one-second enable divider, restartable
// ------------------------------------------------------------
module fbm_tick #(
    parameter int unsigned TICK_CYC = fbm_pkg::TICK_CYC
) (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic clear_i,
    output logic tick_o
);
    import fbm_pkg::*;

    // refuse a divider the counter cannot hold
    if (TICK_CYC < 2 || TICK_CYC > (1 << TICK_W)) begin : g_chk
        $error("fbm_tick: TICK_CYC out of range");
    end

    localparam logic [TICK_W-1:0] LAST = TICK_W'(TICK_CYC - 1); // terminal count

    typedef struct packed {
        logic [TICK_W-1:0] cnt; // cycles in current second
        logic tick; // registered pulse
    } fbm_tick_st_type;

    fbm_tick_st_type st_ff; // state
    fbm_tick_st_type nxt_st; // next state

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        nxt_st = st_ff;
        nxt_st.tick = 1'b0;
        if (clear_i) begin
            // clear restarts a full second, no early tick
            nxt_st.cnt = '0;
        end else if (st_ff.cnt == LAST) begin
            nxt_st.cnt = '0;
            nxt_st.tick = 1'b1;
        end else begin
            nxt_st.cnt = st_ff.cnt + 1'b1;
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign tick_o = st_ff.tick;

endmodule : fbm_tick

// *** verification/fbm_master_model.sv ***
`timescale 1ns/100ps
// ------------------------------------------------------------
// far side: fieldbus master and firmware loader
// ------------------------------------------------------------
module fbm_master_model (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic run_i,
    input wire logic [7:0] period_i,
    input wire logic fw_loading_i,
    input wire logic [7:0] load_delay_i,
    output logic telegram_ok_o,
    output logic fw_load_ok_o
);
    logic [7:0] tel_cnt_ff; // spacing of telegrams
    logic [7:0] load_cnt_ff; // time spent loading
    // periodic one-cycle telegram pulses while running
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tel_cnt_ff <= 8'h00;
            load_cnt_ff <= 8'h00;
            telegram_ok_o <= 1'b0;
            fw_load_ok_o <= 1'b0;
        end else begin
            telegram_ok_o <= run_i && (tel_cnt_ff == period_i - 8'h01);
            tel_cnt_ff <= (!run_i || tel_cnt_ff == period_i - 8'h01) ? 8'h00 : tel_cnt_ff + 8'h01;
            // delay zero means the loader never succeeds
            load_cnt_ff <= (fw_loading_i && load_delay_i != 8'h00) ? load_cnt_ff + 8'h01 : 8'h00;
            fw_load_ok_o <= fw_loading_i && load_delay_i != 8'h00 && load_cnt_ff >= load_delay_i;
        end
    end
endmodule : fbm_master_model

// *** verification/fbm_monitor_asserts.sv ***
`timescale 1ns/100ps
// ------------------------------------------------------------
// port checker for the supervision block
// ------------------------------------------------------------
module fbm_monitor_asserts #(
    parameter int unsigned TICK_CYC = 8
) (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic fw_load_ok_i,
    input wire logic telegram_ok_i,
    input wire fbm_pkg::fbm_cfg_type cfg_active_o,
    input wire logic fw_loading_o,
    input wire logic fw_load_fail_o,
    input wire logic restart_req_o,
    input wire logic can_on_o,
    input wire logic [2:0] can_profile_o,
    input wire logic stack_service_o,
    input wire logic io_service_o,
    input wire logic wd_armed_o,
    input wire logic bus_timeout_o,
    input wire logic shutdown_o
);
    import fbm_pkg::*;
    int cyc_ff; // cycles since reset release
    int quiet_ff; // cycles since last accepted telegram
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);
    // helper counters; telegrams during loading are not accepted
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cyc_ff <= 0;
            quiet_ff <= 0;
        end else begin
            cyc_ff <= cyc_ff + 1;
            quiet_ff <= (telegram_ok_i && !fw_loading_o && !fw_load_fail_o) ? 0 : quiet_ff + 1;
        end
    end
    sequence s_restart_pulse;
        restart_req_o && !fw_loading_o ##1 !restart_req_o;
    endsequence
    a_restart_after_load: assert property (fw_loading_o && fw_load_ok_i |=> s_restart_pulse)
        else $error("no restart pulse after load");
    a_cfg_frozen_run: assert property (cyc_ff >= 2 |-> $stable(cfg_active_o))
        else $error("active config changed");
    a_can_moves_service: assert property (io_service_o == (cfg_active_o.can_mode != 3'h0) && can_on_o == io_service_o)
        else $error("service link routing wrong");
    a_profile_map: assert property (can_profile_o == ((cfg_active_o.can_mode >= 3'h2) ? cfg_active_o.can_mode - 3'h1 : 3'h0))
        else $error("profile number wrong");
    a_boot_window_open: assert property (cyc_ff < 5 * TICK_CYC - 1 || !can_on_o |-> stack_service_o)
        else $error("stack service port closed early");
    a_trip_needs_arm: assert property ($rose(bus_timeout_o) |-> $past(wd_armed_o))
        else $error("trip while unarmed");
    a_zero_never_arms: assert property (cfg_active_o.timeout_s == 7'h00 |-> !wd_armed_o && !bus_timeout_o)
        else $error("monitoring active with zero timeout");
    a_trip_timing: assert property ($rose(bus_timeout_o) |->
        quiet_ff >= int'(cfg_active_o.timeout_s) * TICK_CYC
        && quiet_ff <= int'(cfg_active_o.timeout_s) * TICK_CYC + 2)
        else $error("trip at wrong silence length");
    a_trip_sticky: assert property (bus_timeout_o |=> bus_timeout_o && shutdown_o)
        else $error("trip not held");
endmodule : fbm_monitor_asserts
bind fbm_monitor fbm_monitor_asserts #(.TICK_CYC(TICK_CYC)) u_chk (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
    .fw_load_ok_i(fw_load_ok_i), .telegram_ok_i(telegram_ok_i), .cfg_active_o(cfg_active_o),
    .fw_loading_o(fw_loading_o), .fw_load_fail_o(fw_load_fail_o), .restart_req_o(restart_req_o),
    .can_on_o(can_on_o), .can_profile_o(can_profile_o), .stack_service_o(stack_service_o),
    .io_service_o(io_service_o), .wd_armed_o(wd_armed_o), .bus_timeout_o(bus_timeout_o), .shutdown_o(shutdown_o));

// *** verification/fieldbus_config_timeout_monitor_tb.sv ***
`timescale 1ns/100ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin failures++; \
    $display("unexpected at %0t: got %0h want %0h", $time, g, e); end end
module fieldbus_config_timeout_monitor_tb;
    import fbm_pkg::*;
    localparam int TK = 8; // shortened second
    logic core_clk = 1'b0, rst_n = 1'b0, fw_load_ok, telegram_ok, run = 1'b0;
    fbm_cfg_type cfg = '0, cfg_act;
    logic [7:0] addr_sw = 8'h00, period = 8'h0a, load_delay = 8'h14;
    logic [1:0] fw_proto = 2'h0;
    logic p_valid, ld_start, loading, ld_fail, restart, can_on, stack_svc, io_svc, r_valid, armed, bus_to, shut;
    logic [2:0] prof;
    logic [6:0] node;
    logic [9:0] kbps;
    int failures = 0, tests_run = 0, cyc = 0, last_tel = 0;
    always #4 core_clk = ~core_clk;
    // cycle count and time of the last telegram
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (telegram_ok) last_tel <= cyc;
    end
    fbm_monitor #(.TICK_CYC(TK)) dut (.core_clk_i(core_clk), .rst_n_i(rst_n), .cfg_i(cfg), .addr_sw_i(addr_sw),
        .fw_proto_i(fw_proto), .fw_load_ok_i(fw_load_ok), .telegram_ok_i(telegram_ok), .cfg_active_o(cfg_act),
        .proto_valid_o(p_valid), .fw_load_start_o(ld_start), .fw_loading_o(loading), .fw_load_fail_o(ld_fail),
        .restart_req_o(restart), .can_on_o(can_on), .can_profile_o(prof), .stack_service_o(stack_svc),
        .io_service_o(io_svc), .node_addr_o(node), .can_kbps_o(kbps), .rate_valid_o(r_valid),
        .wd_armed_o(armed), .bus_timeout_o(bus_to), .shutdown_o(shut));
    fbm_master_model u_master (.core_clk_i(core_clk), .rst_n_i(rst_n), .run_i(run), .period_i(period),
        .fw_loading_i(loading), .load_delay_i(load_delay), .telegram_ok_o(telegram_ok), .fw_load_ok_o(fw_load_ok));
    // pseudo-random source, fixed start
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    // reference rate table in kbit/s
    function automatic int exp_kbps(input int code);
        case (code)
            0: return 1000;
            2: return 500;
            3: return 250;
            4: return 125;
            6: return 50;
            7: return 20;
            8: return 10;
            default: return 0;
        endcase
    endfunction : exp_kbps
    // power cycle with new stored settings; returns after capture edge
    task automatic boot(input fbm_cfg_type c, input logic [7:0] sw, input logic [1:0] fp);
        @(posedge core_clk);
        cfg <= c;
        addr_sw <= sw;
        fw_proto <= fp;
        rst_n <= 1'b0;
        repeat (2) @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
        #1;
    endtask : boot
    task automatic conclude();
        $display("checks %0d, mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : conclude
    initial begin
        #100000;
        failures++;
        conclude();
    end
    initial begin
        logic [31:0] rnd;
        fbm_cfg_type c;
        logic [7:0] sw;
        logic [2:0] m;
        int d;
        rnd = 32'hec7ea191;
        // every can mode and rate codes 0 to 9, with clamping cases
        for (int i = 0; i < 10; i++) begin
            rnd = lfsr(rnd);
            c = '{proto: 2'(i), can_mode: 3'(i), node_addr: rnd[6:0], rate_code: 4'(i), timeout_s: 7'(i * 13)};
            sw = (i % 3 == 0) ? (rnd[15:8] | 8'h01) : 8'h00;
            // mode field keeps the low three bits; codes above six fall back to off
            m = (3'(i) > 3'h6) ? 3'h0 : 3'(i);
            boot(c, sw, c.proto);
            `CHK(can_on, m != 3'h0)
            `CHK(io_svc, m != 3'h0)
            `CHK(prof, (m >= 3'h2) ? m - 3'h1 : 3'h0)
            `CHK(kbps, 10'(exp_kbps(i)))
            `CHK(r_valid, exp_kbps(i) != 0)
            `CHK(node, (sw == 8'h00) ? c.node_addr : sw[6:0])
            `CHK(p_valid, 1'b1)
            `CHK(cfg_act.timeout_s, (i * 13 > 100) ? 7'h64 : 7'(i * 13))
            `CHK(loading, 1'b0)
            `CHK(stack_svc, 1'b1)
            @(posedge core_clk);
            cfg.node_addr <= ~c.node_addr;
            repeat (45) @(posedge core_clk);
            #1;
            `CHK(node, (sw == 8'h00) ? c.node_addr : sw[6:0])
            `CHK(stack_svc, m == 3'h0)
        end
        // protocol change loads once, then asks for restart; power stays on meanwhile
        c = '{proto: 2'h1, can_mode: 3'h0, node_addr: 7'h00, rate_code: 4'h2, timeout_s: 7'h02};
        boot(c, 8'h00, 2'h0);
        `CHK(ld_start, 1'b1)
        `CHK(loading, 1'b1)
        d = 0;
        while (restart !== 1'b1 && d < 200) begin
            @(posedge core_clk);
            #1;
            d++;
        end
        `CHK(restart, 1'b1)
        `CHK(loading, 1'b0)
        // loader that never reports success
        @(posedge core_clk);
        load_delay <= 8'h00;
        boot(c, 8'h00, 2'h0);
        repeat (120 * TK + 20) @(posedge core_clk);
        #1;
        `CHK(ld_fail, 1'b1)
        // watchdog: unarmed, fed, then starved
        boot(c, 8'h00, 2'h1);
        repeat (40) @(posedge core_clk);
        #1;
        `CHK(armed, 1'b0)
        `CHK(bus_to, 1'b0)
        @(posedge core_clk);
        run <= 1'b1;
        repeat (80) @(posedge core_clk);
        #1;
        `CHK(armed, 1'b1)
        `CHK(bus_to, 1'b0)
        run <= 1'b0;
        d = 0;
        while (bus_to !== 1'b1 && d < 60) begin
            @(posedge core_clk);
            #1;
            d++;
        end
        d = cyc - last_tel;
        `CHK(d >= 2 * TK && d <= 2 * TK + 3, 1'b1)
        `CHK(shut, 1'b1)
        // zero timeout disables monitoring
        c.timeout_s = 7'h00;
        boot(c, 8'h00, 2'h1);
        @(posedge core_clk);
        run <= 1'b1;
        repeat (30) @(posedge core_clk);
        run <= 1'b0;
        repeat (60) @(posedge core_clk);
        #1;
        `CHK(bus_to, 1'b0)
        `CHK(armed, 1'b0)
        conclude();
    end
endmodule : fieldbus_config_timeout_monitor_tb
